// ### shared/profile_switch_pkg.sv
// constants and types for the profile switch controller
// assumes a single 25 MHz clock domain
package profile_switch_pkg;
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          SWITCH_TIME_NS = 50_000;
  localparam int          SWITCH_CYCLES  = SWITCH_TIME_NS / (1_000_000_000 / CLK_HZ);
  localparam int          MAX_PROFILES   = 6;
  localparam int          IDX_W          = 3;
  localparam int          DEC_W          = 4;
  localparam int          CAL_CYCLES     = 16;
  localparam logic [2:0]  IDX_LOWEST     = 3'h0;
  localparam logic [2:0]  IDX_HIGHEST    = 3'h5;
  localparam logic [3:0]  DEC_MAIN       = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CAL_MAIN,
    ST_CAL_DYN,
    ST_READY,
    ST_SWITCH
  } state_type;
endpackage

// ### design/profile_switch_ctrl.sv
// dynamic profile switching controller, single clock
// assumes config inputs are stable while config_valid_i is sampled and
// that the baseband processor arms all channels before requesting a switch
`timescale 1ns/1ps
module profile_switch_ctrl #(
  parameter int SWITCH_CNT = profile_switch_pkg::SWITCH_CYCLES
) (
  input  wire logic                               clk_i,
  input  wire logic                               arst_n_i,
  input  wire logic                               config_valid_i,
  input  wire logic [3:0]                         num_profiles_i,
  input  wire logic [5:0]                         custom_filter_i,
  input  wire logic                               hop_mode_i,
  input  wire logic                               switch_req_i,
  input  wire logic [profile_switch_pkg::IDX_W-1:0] next_profile_i,
  input  wire logic                               all_armed_i,
  input  wire logic                               tx_enable_pin_i,
  input  wire logic                               rx_enable_pin_i,
  output logic                                    config_err_o,
  output logic                                    cal_done_o,
  output logic                                    switch_busy_o,
  output logic                                    switch_reject_o,
  output logic                                    switch_done_o,
  output logic [profile_switch_pkg::IDX_W-1:0]      active_profile_o,
  output logic [profile_switch_pkg::DEC_W-1:0]      decim_ratio_o,
  output logic                                    filter_custom_o,
  output logic                                    filter_load_o,
  output logic [profile_switch_pkg::IDX_W-1:0]      stream_rate_idx_o,
  output logic                                    tx_enable_o,
  output logic                                    rx_enable_o
);
  import profile_switch_pkg::*;

  if (SWITCH_CNT < 1 || SWITCH_CNT > 65535) begin : bad_switch_cnt
    $error("SWITCH_CNT out of range");
  end

  // decimation relative to the main profile: one power of two per index step
  function automatic logic [DEC_W-1:0] decim_of(input logic [IDX_W-1:0] idx,
                                                input logic [IDX_W-1:0] main_idx);
    decim_of = DEC_W'(main_idx - idx);
  endfunction

  function automatic logic idx_ok(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] top);
    idx_ok = (idx <= top);
  endfunction

  // pin synchronisers, three stages, change taken when stages two and three agree
  logic [2:0] tx_sync_ff;
  logic [2:0] rx_sync_ff;
  logic       tx_level_ff;
  logic       rx_level_ff;
  logic [2:0] nxt_tx_sync;
  logic [2:0] nxt_rx_sync;
  logic       nxt_tx_level;
  logic       nxt_rx_level;

  always_comb begin
    nxt_tx_sync  = {tx_sync_ff[1:0], tx_enable_pin_i};
    nxt_rx_sync  = {rx_sync_ff[1:0], rx_enable_pin_i};
    nxt_tx_level = tx_level_ff;
    nxt_rx_level = rx_level_ff;
    if (tx_sync_ff[1] == tx_sync_ff[2]) begin
      nxt_tx_level = tx_sync_ff[2];
    end
    if (rx_sync_ff[1] == rx_sync_ff[2]) begin
      nxt_rx_level = rx_sync_ff[2];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_sync_ff  <= 3'h0;
      rx_sync_ff  <= 3'h0;
      tx_level_ff <= 1'b0;
      rx_level_ff <= 1'b0;
    end else begin
      tx_sync_ff  <= nxt_tx_sync;
      rx_sync_ff  <= nxt_rx_sync;
      tx_level_ff <= nxt_tx_level;
      rx_level_ff <= nxt_rx_level;
    end
  end

  // control state
  state_type        state_ff;
  state_type        nxt_state;
  logic [15:0]      cnt_ff;
  logic [15:0]      nxt_cnt;
  logic [IDX_W-1:0] main_idx_ff;
  logic [IDX_W-1:0] nxt_main_idx;
  logic [IDX_W-1:0] cal_idx_ff;
  logic [IDX_W-1:0] nxt_cal_idx;
  logic [IDX_W-1:0] active_ff;
  logic [IDX_W-1:0] nxt_active;
  logic [IDX_W-1:0] pending_ff;
  logic [IDX_W-1:0] nxt_pending;
  logic [5:0]       custom_ff;
  logic [5:0]       nxt_custom;
  logic [DEC_W-1:0] decim_ff;
  logic [DEC_W-1:0] nxt_decim;
  logic             fcust_ff;
  logic             nxt_fcust;
  logic             fload_ff;
  logic             nxt_fload;
  logic             err_ff;
  logic             nxt_err;
  logic             rej_ff;
  logic             nxt_rej;
  logic             done_ff;
  logic             nxt_done;
  logic             cfg_ok;

  // more than six profiles, fewer than two, or hopping enabled is refused
  assign cfg_ok = (num_profiles_i <= 4'(MAX_PROFILES)) && (num_profiles_i > 4'h1)
                  && !hop_mode_i;

  always_comb begin
    nxt_state    = state_ff;
    nxt_cnt      = cnt_ff;
    nxt_main_idx = main_idx_ff;
    nxt_cal_idx  = cal_idx_ff;
    nxt_active   = active_ff;
    nxt_pending  = pending_ff;
    nxt_custom   = custom_ff;
    nxt_decim    = decim_ff;
    nxt_fcust    = fcust_ff;
    nxt_fload    = 1'b0;
    nxt_err      = err_ff;
    nxt_rej      = 1'b0;
    nxt_done     = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (config_valid_i) begin
          if (cfg_ok) begin
            nxt_err      = 1'b0;
            // highest index holds the highest rate and is the main profile
            nxt_main_idx = IDX_W'(num_profiles_i - 4'h1);
            nxt_custom   = custom_filter_i;
            nxt_cal_idx  = IDX_W'(num_profiles_i - 4'h1);
            nxt_cnt      = 16'(CAL_CYCLES);
            nxt_state    = ST_CAL_MAIN;
          end else begin
            nxt_err = 1'b1;
          end
        end
      end
      ST_CAL_MAIN: begin
        if (cnt_ff == 16'h0) begin
          nxt_cal_idx = IDX_LOWEST;
          nxt_cnt     = 16'(CAL_CYCLES);
          nxt_state   = ST_CAL_DYN;
        end else begin
          nxt_cnt = cnt_ff - 16'h1;
        end
      end
      ST_CAL_DYN: begin
        if (cnt_ff != 16'h0) begin
          nxt_cnt = cnt_ff - 16'h1;
        end else if (cal_idx_ff + IDX_W'(1) >= main_idx_ff) begin
          nxt_active = main_idx_ff;
          nxt_decim  = DEC_MAIN;
          nxt_fcust  = custom_ff[main_idx_ff];
          nxt_fload  = 1'b1;
          nxt_state  = ST_READY;
        end else begin
          nxt_cal_idx = cal_idx_ff + IDX_W'(1);
          nxt_cnt     = 16'(CAL_CYCLES);
        end
      end
      ST_READY: begin
        if (switch_req_i) begin
          if (all_armed_i && idx_ok(next_profile_i, main_idx_ff)) begin
            nxt_pending = next_profile_i;
            nxt_cnt     = 16'(SWITCH_CNT - 1);
            nxt_state   = ST_SWITCH;
          end else begin
            nxt_rej = 1'b1;
          end
        end
      end
      ST_SWITCH: begin
        if (switch_req_i) begin
          nxt_rej = 1'b1;
        end
        if (cnt_ff == 16'h0) begin
          // one shared set for every channel
          nxt_active = pending_ff;
          nxt_decim  = decim_of(pending_ff, main_idx_ff);
          nxt_fcust  = custom_ff[pending_ff];
          nxt_fload  = 1'b1;
          nxt_done   = 1'b1;
          nxt_state  = ST_READY;
        end else begin
          nxt_cnt = cnt_ff - 16'h1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 16'h0;
      main_idx_ff <= IDX_HIGHEST;
      cal_idx_ff  <= IDX_LOWEST;
      active_ff   <= IDX_LOWEST;
      pending_ff  <= IDX_LOWEST;
      custom_ff   <= 6'h00;
      decim_ff    <= DEC_MAIN;
      fcust_ff    <= 1'b0;
      fload_ff    <= 1'b0;
      err_ff      <= 1'b0;
      rej_ff      <= 1'b0;
      done_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      main_idx_ff <= nxt_main_idx;
      cal_idx_ff  <= nxt_cal_idx;
      active_ff   <= nxt_active;
      pending_ff  <= nxt_pending;
      custom_ff   <= nxt_custom;
      decim_ff    <= nxt_decim;
      fcust_ff    <= nxt_fcust;
      fload_ff    <= nxt_fload;
      err_ff      <= nxt_err;
      rej_ff      <= nxt_rej;
      done_ff     <= nxt_done;
    end
  end

  assign config_err_o      = err_ff;
  assign cal_done_o        = (state_ff == ST_READY) || (state_ff == ST_SWITCH);
  assign switch_busy_o     = (state_ff == ST_SWITCH);
  assign switch_reject_o   = rej_ff;
  assign switch_done_o     = done_ff;
  assign active_profile_o  = active_ff;
  assign decim_ratio_o     = decim_ff;
  assign filter_custom_o   = fcust_ff;
  assign filter_load_o     = fload_ff;
  assign stream_rate_idx_o = main_idx_ff;
  // enable pins pass only when operating and not switching
  assign tx_enable_o = tx_level_ff && (state_ff == ST_READY);
  assign rx_enable_o = rx_level_ff && (state_ff == ST_READY);

  // checking aid: length of the current busy stretch
  logic [15:0] busy_len_ff;
  logic [15:0] nxt_busy_len;
  always_comb begin
    nxt_busy_len = 16'h0;
    if (switch_busy_o) begin
      nxt_busy_len = busy_len_ff + 16'h1;
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_len_ff <= 16'h0;
    end else begin
      busy_len_ff <= nxt_busy_len;
    end
  end

  // assertions
  sequence accept_s;
    state_ff == ST_READY && switch_req_i && all_armed_i && idx_ok(next_profile_i, main_idx_ff);
  endsequence

  accept_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept_s |=> switch_busy_o && !switch_reject_o)
    else $error("accepted request did not start a switch");

  switch_time_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(switch_busy_o) |-> switch_done_o && busy_len_ff == 16'(SWITCH_CNT))
    else $error("switch did not finish on time");

  busy_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    switch_busy_o |-> !tx_enable_o && !rx_enable_o)
    else $error("enable passed during switch");

  busy_reject_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    switch_busy_o && switch_req_i && !switch_done_o |=> switch_reject_o)
    else $error("request not rejected while busy");

  too_many_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_IDLE && config_valid_i && num_profiles_i > 4'(MAX_PROFILES)
      |=> config_err_o && state_ff == ST_IDLE)
    else $error("oversized configuration accepted");

  hop_excl_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_IDLE && config_valid_i && hop_mode_i |=> state_ff == ST_IDLE)
    else $error("hopping and switching both enabled");

  main_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_CAL_DYN && nxt_state == ST_READY
      |=> active_profile_o == main_idx_ff && decim_ratio_o == DEC_MAIN)
    else $error("main profile not active after calibration");

  cal_order_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    state_ff == ST_CAL_DYN |-> $past(state_ff) inside {ST_CAL_MAIN, ST_CAL_DYN})
    else $error("dynamic calibration before main");

  rate_fixed_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cal_done_o |=> $stable(stream_rate_idx_o))
    else $error("stream rate changed");

  decim_apply_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    switch_done_o |-> decim_ratio_o == DEC_W'(main_idx_ff - active_profile_o) && filter_load_o)
    else $error("wrong decimation after switch");
endmodule

// ### dv/baseband_model.sv
// bench model of the baseband processor facing the switch controller
// assumes the bench drives go_i, arm_i and idx_i on the rising edge
`timescale 1ns/1ps
module baseband_model (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       go_i,
  input  wire logic       arm_i,
  input  wire logic [2:0] idx_i,
  output logic            all_armed_o,
  output logic            switch_req_o,
  output logic [2:0]      next_profile_o
);
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      all_armed_o    <= 1'b0;
      switch_req_o   <= 1'b0;
      next_profile_o <= 3'h0;
    end else begin
      all_armed_o    <= arm_i;
      switch_req_o   <= go_i;
      // index only meaningful with a request, scrambled otherwise
      next_profile_o <= go_i ? idx_i : ~next_profile_o;
    end
  end
endmodule

// ### dv/profile_switch_ctrl_test.sv
// self-checking bench for the profile switch controller
// assumes baseband_model and a shortened switch count
`timescale 1ns/1ps
module profile_switch_ctrl_test;
  import profile_switch_pkg::*;
  localparam int SW = 6;
  logic       clk_i = 1'b0, arst_n_i = 1'b0, config_valid_i = 1'b0, hop_mode_i = 1'b0;
  logic [3:0] num_profiles_i = 4'h0;
  logic [5:0] custom_filter_i = 6'h0, custom;
  logic       tx_pin = 1'b0, rx_pin = 1'b0, go = 1'b0, arm = 1'b0;
  logic [2:0] idx = 3'h0, next_profile, active_profile_o, stream_rate_idx_o;
  logic [3:0] decim_ratio_o;
  logic       all_armed, switch_req, config_err_o, cal_done_o, switch_busy_o;
  logic       switch_reject_o, switch_done_o, filter_custom_o, filter_load_o;
  logic       tx_enable_o, rx_enable_o;
  int mismatches = 0, checked = 0, n, main, c, rej_cnt = 0, done_cnt = 0, load_cnt = 0;
  int busy_cnt = 0, leak = 0, exp_a, r0, b0;
  int plan[2] = '{6, 3};
  int exp_q[$];

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  profile_switch_ctrl #(.SWITCH_CNT(SW)) profile_switch_ctrl_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .config_valid_i(config_valid_i),
    .num_profiles_i(num_profiles_i), .custom_filter_i(custom_filter_i),
    .hop_mode_i(hop_mode_i), .switch_req_i(switch_req), .next_profile_i(next_profile),
    .all_armed_i(all_armed), .tx_enable_pin_i(tx_pin), .rx_enable_pin_i(rx_pin),
    .config_err_o(config_err_o), .cal_done_o(cal_done_o), .switch_busy_o(switch_busy_o),
    .switch_reject_o(switch_reject_o), .switch_done_o(switch_done_o),
    .active_profile_o(active_profile_o), .decim_ratio_o(decim_ratio_o),
    .filter_custom_o(filter_custom_o), .filter_load_o(filter_load_o),
    .stream_rate_idx_o(stream_rate_idx_o), .tx_enable_o(tx_enable_o),
    .rx_enable_o(rx_enable_o));

  baseband_model baseband_model_i (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .go_i(go), .arm_i(arm), .idx_i(idx),
    .all_armed_o(all_armed), .switch_req_o(switch_req), .next_profile_o(next_profile));

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_n(input string nm, input int e, input int g);
    checked++;
    if (g != e) begin
      mismatches++;
      $display("FAIL %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      mismatches++;
      $display("FAIL wait expected below %0d seen %0d", lim, k);
      print_verdict();
    end
  endtask

  // model side: every completion is compared with the queued target
  always @(negedge clk_i) begin
    if (switch_reject_o === 1'b1) rej_cnt++;
    if (switch_busy_o === 1'b1) busy_cnt++;
    if (switch_busy_o === 1'b1 && (tx_enable_o !== 1'b0 || rx_enable_o !== 1'b0)) leak++;
    if (filter_load_o === 1'b1) load_cnt++;
    if (switch_done_o === 1'b1) begin
      done_cnt++;
      exp_a = (exp_q.size() > 0) ? exp_q.pop_front() : 7;
      chk("active", 4'(exp_a), {1'b0, active_profile_o});
      chk("decim", 4'(main - exp_a), decim_ratio_o);
      chk("filter", {3'h0, custom[exp_a]}, {3'h0, filter_custom_o});
      chk("rate", 4'(main), {1'b0, stream_rate_idx_o});
      chk("busy at done", 4'h0, {3'h0, switch_busy_o});
    end
  end

  task automatic req(input logic [2:0] t);
    @(posedge clk_i);
    go  <= 1'b1;
    idx <= t;
    @(posedge clk_i);
    go  <= 1'b0;
  endtask

  task automatic cfg(input logic [3:0] k, input logic h);
    @(posedge clk_i);
    config_valid_i  <= 1'b1;
    num_profiles_i  <= k;
    hop_mode_i      <= h;
    custom_filter_i <= custom;
    @(posedge clk_i);
    config_valid_i  <= 1'b0;
    hop_mode_i      <= 1'b0;
  endtask

  task automatic do_switch(input logic [2:0] t);
    int d0, l0, k;
    d0 = done_cnt;
    l0 = load_cnt;
    r0 = rej_cnt;
    b0 = busy_cnt;
    exp_q.push_back(int'(t));
    @(posedge clk_i);
    tx_pin <= 1'b1;
    rx_pin <= 1'b1;
    req(t);
    k = 0;
    while (switch_busy_o !== 1'b1 && k < 10) begin
      @(negedge clk_i);
      k++;
    end
    tmo(k, 10);
    req(t ^ 3'h1);
    k = 0;
    while (done_cnt == d0 && k < 60) begin
      @(negedge clk_i);
      k++;
    end
    tmo(k, 60);
    chk_n("busy cycles", SW, busy_cnt - b0);
    chk_n("reject busy", 1, rej_cnt - r0);
    chk_n("done pulses", 1, done_cnt - d0);
    chk_n("load pulses", 1, load_cnt - l0);
    chk_n("pin leak", 0, leak);
  endtask

  task automatic refused(input logic [2:0] t);
    r0 = rej_cnt;
    b0 = busy_cnt;
    req(t);
    repeat (6) @(negedge clk_i);
    chk_n("reject", 1, rej_cnt - r0);
    chk_n("no busy", 0, busy_cnt - b0);
  endtask

  initial begin
    void'($urandom(92698));
    foreach (plan[p]) begin
      n = plan[p];
      main = n - 1;
      custom = 6'($urandom);
      @(posedge clk_i);
      arst_n_i <= 1'b0;
      arm      <= 1'b0;
      repeat (12) @(posedge clk_i);
      chk("rate rst", {1'b0, IDX_HIGHEST}, {1'b0, stream_rate_idx_o});
      chk("active rst", 4'h0, {1'b0, active_profile_o});
      chk("ready rst", 4'h0, {3'h0, cal_done_o});
      arst_n_i <= 1'b1;
      if (p == 0) begin
        cfg(4'h7, 1'b0);
        repeat (2) @(negedge clk_i);
        chk("err seven", 4'h1, {3'h0, config_err_o});
        cfg(4'h1, 1'b0);
        repeat (2) @(negedge clk_i);
        chk("err one", 4'h1, {3'h0, config_err_o});
        cfg(4'h4, 1'b1);
        repeat (2) @(negedge clk_i);
        chk("err hop", 4'h1, {3'h0, config_err_o});
      end
      cfg(4'(n), 1'b0);
      c = 0;
      while (cal_done_o !== 1'b1 && c < 300) begin
        @(negedge clk_i);
        c++;
      end
      tmo(c, 300);
      chk_n("cal cycles", (CAL_CYCLES + 1) * n, c - 1);
      chk("main active", 4'(main), {1'b0, active_profile_o});
      chk("main decim", {DEC_MAIN}, decim_ratio_o);
      chk("main filter", {3'h0, custom[main]}, {3'h0, filter_custom_o});
      chk("rate", 4'(main), {1'b0, stream_rate_idx_o});
      chk("err clear", 4'h0, {3'h0, config_err_o});
      @(posedge clk_i);
      tx_pin <= 1'b1;
      rx_pin <= 1'b0;
      arm    <= 1'b1;
      repeat (6) @(negedge clk_i);
      chk("tx pass", 4'h1, {3'h0, tx_enable_o});
      chk("rx pass", 4'h0, {3'h0, rx_enable_o});
      do_switch(3'h0);
      do_switch(3'(main));
      do_switch(3'($urandom_range(main, 0)));
      refused(3'(main + 1));
      @(posedge clk_i);
      arm <= 1'b0;
      refused(3'h1);
      $display("test with %0d profiles done", n);
    end
    print_verdict();
  end
endmodule
